// [pio_ports_map.svh]
// Register offsets, reset values, field positions and widths of the
// three-port parallel I/O block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PIO_PORTS_MAP_SVH
`define PIO_PORTS_MAP_SVH

`define ADDR_W           8
`define DATA_W           8
`define FIVE_W           5
`define CHAN_SEL_W       5

`define OFS_FIRST_LATCH  8'h00
`define OFS_SHARED_LATCH 8'h01
`define OFS_FIVE_LATCH   8'h02
`define OFS_FIRST_DIR    8'h04
`define OFS_SHARED_DIR   8'h05
`define OFS_FIVE_DIR     8'h06

`define DIR_RESET        8'h00
`define FIVE_DIR_RESET   5'h00
`define CLK_OUT_RESET    1'b0
`define READ_IDLE        8'h00
`define ZERO_BYTE        8'h00

`define CLK_OUT_EN_BIT   7
`define CLK_OUT_PIN      2

`define SHARED_PINS      8
`define SHARED_CHAN_BASE 5'h00
`define CONV_CHANNELS    5'h0f

`endif

// [pio_ports_pkg.sv]
// Types shared by the parallel I/O block and its leaf modules.
// Assumes the constants header is on the include path.
`include "pio_ports_map.svh"

package pio_ports_pkg;

  // One register access as the bus master presents it.
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic               wr;
    logic               rd;
  } bus_req_t;

  // What one eight-pin port shows to the pins and to the read path.
  typedef struct packed {
    logic [`DATA_W-1:0] out;
    logic [`DATA_W-1:0] oe_n;
    logic [`DATA_W-1:0] rd_val;
  } port_view_t;

endpackage : pio_ports_pkg

// [pio_pin_sync.sv]
// Two-flop synchroniser for a group of pin inputs.
// Assumes the pins are free of any relation to clk.
`timescale 1ns/1ns

module pio_pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        meta_d[i] = pin_in[i];
        sync_d[i] = meta_q[i];
      end
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= meta_d[i];
          sync_q[i] <= sync_d[i];
        end
      end
    end
  endgenerate

  assign pin_sync = sync_q;

endmodule : pio_pin_sync

// [pio_port_slice.sv]
// Per-pin drive and read selection for one eight-pin port.
// Assumes synchronised pin levels and zeroed inputs for absent pins.
`timescale 1ns/1ns
`include "pio_ports_map.svh"

module pio_port_slice
  import pio_ports_pkg::*;
(
  input  wire logic [`DATA_W-1:0] latch,
  input  wire logic [`DATA_W-1:0] dir,
  input  wire logic [`DATA_W-1:0] analog,
  input  wire logic [`DATA_W-1:0] force_drive,
  input  wire logic [`DATA_W-1:0] pin_sync,
  output port_view_t              view
);

  genvar i;
  generate
    for (i = 0; i < `DATA_W; i++) begin : g_pin
      logic eff_dir;
      logic drive;
      always_comb begin
        eff_dir = dir[i] | force_drive[i];
        // A pin taken by the converter never drives.
        drive = eff_dir & ~analog[i]; // R8
        view.oe_n[i] = ~drive; // R2
        view.out[i] = latch[i] & drive;
        if (eff_dir) begin
          view.rd_val[i] = latch[i]; // R4 R9
        end else if (analog[i]) begin
          view.rd_val[i] = 1'b0; // R9
        end else begin
          view.rd_val[i] = pin_sync[i]; // R5
        end
      end
    end
  endgenerate

endmodule : pio_port_slice

// [pio_ports_abc.sv]
// Three parallel I/O ports: an eight-bit general port, an eight-bit port
// shared with converter channels, and a five-bit port with clock output.
// Assumes a single-cycle strobe master on clk and a converter that
// presents its channel select field as a steady input.
//
// What this block does
// (R1) First port latch is read/write and keeps its contents through reset.
// (R2) Direction bit 1 drives the pin; 0 leaves it high impedance.
// (R3) Reset clears all first port direction bits, making every pin input.
// (R4) With direction 1, a data read returns the stored latch bit.
// (R5) With direction 0, a data read returns the sensed pin level.
// (R6) Latch writes work in any direction; input pins stay unaffected. The five-bit pin 2 latch ignores writes while clock output is enabled.
// (R7) Software should load the latch before turning a pin to output.
// (R8) Channel select makes a shared pin analog; such pins never drive.
// (R9) Analog pin reads give 0 for direction 0, latch for direction 1.
// (R10) Shared port has eight pins, eight of sixteen converter channels.
// (R11) Reset clears shared port direction; its latch keeps its contents.
// (R12) Five-bit port has read/write latches kept through reset, plus direction.
// (R13) Clock output enable, direction bit 7, puts bus clock on pin 2.
// (R14) Reset clears clock output enable; software may read and write it.
// (R15) Five-bit direction bits are read/write; reset makes all pins inputs.
// (R16) Registers are byte wide; writes land on the edge ending the cycle.
// (R17) Pin levels pass a two-flop synchroniser before the read path.
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`include "pio_ports_map.svh"

module pio_ports_abc
  import pio_ports_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic [`ADDR_W-1:0]     addr,
  input  wire logic [`DATA_W-1:0]     wdata,
  input  wire logic                   wr_stb,
  input  wire logic                   rd_stb,
  output logic      [`DATA_W-1:0]     rd_data,
  input  wire logic [`CHAN_SEL_W-1:0] converter_channel_select,
  input  wire logic [`DATA_W-1:0]     first_port_in,
  output logic      [`DATA_W-1:0]     first_port_out,
  output logic      [`DATA_W-1:0]     first_port_oe_n,
  input  wire logic [`DATA_W-1:0]     shared_port_in,
  output logic      [`DATA_W-1:0]     shared_port_out,
  output logic      [`DATA_W-1:0]     shared_port_oe_n,
  input  wire logic [`FIVE_W-1:0]     five_port_in,
  output logic      [`FIVE_W-1:0]     five_port_out,
  output logic      [`FIVE_W-1:0]     five_port_oe_n
);

  // Shared pin i belongs to converter channel base + i.
  function automatic logic [`DATA_W-1:0] chan_to_mask(
    input logic [`CHAN_SEL_W-1:0] ch
  );
    logic [`CHAN_SEL_W-1:0] rel;
    chan_to_mask = `ZERO_BYTE;
    rel = ch - `SHARED_CHAN_BASE;
    if (ch <= `CONV_CHANNELS
        && rel < `CHAN_SEL_W'(`SHARED_PINS)) begin
      chan_to_mask[rel[2:0]] = 1'b1; // R10
    end
  endfunction : chan_to_mask

  // Zero-extends a five-bit quantity to a full byte.
  function automatic logic [`DATA_W-1:0] widen(
    input logic [`FIVE_W-1:0] v
  );
    widen = {{(`DATA_W-`FIVE_W){1'b0}}, v};
  endfunction : widen

  bus_req_t req;

  always_comb begin
    req.addr = addr;
    req.wdata = wdata;
    req.wr = wr_stb;
    req.rd = rd_stb;
  end

  // Data latches: no reset, so their contents survive a system reset.
  logic [`DATA_W-1:0] first_port_latch_q;
  logic [`DATA_W-1:0] first_port_latch_d;
  logic [`DATA_W-1:0] analog_shared_port_latch_q;
  logic [`DATA_W-1:0] analog_shared_port_latch_d;
  logic [`FIVE_W-1:0] five_bit_port_latch_q;
  logic [`FIVE_W-1:0] five_bit_port_latch_d;

  // Direction registers and the clock output enable.
  logic [`DATA_W-1:0] first_port_direction_q;
  logic [`DATA_W-1:0] first_port_direction_d;
  logic [`DATA_W-1:0] analog_shared_port_direction_q;
  logic [`DATA_W-1:0] analog_shared_port_direction_d;
  logic [`FIVE_W-1:0] five_bit_port_direction_q;
  logic [`FIVE_W-1:0] five_bit_port_direction_d;
  logic               clock_output_enable_q;
  logic               clock_output_enable_d;

  logic [`DATA_W-1:0] rd_data_q;
  logic [`DATA_W-1:0] rd_data_d;

  logic [`DATA_W-1:0] first_sync;
  logic [`DATA_W-1:0] shared_sync;
  logic [`FIVE_W-1:0] five_sync;

  logic [`DATA_W-1:0] analog_mask;
  logic [`DATA_W-1:0] five_force;
  port_view_t         first_view;
  port_view_t         shared_view;
  port_view_t         five_view;

  logic wr_first_latch;
  logic wr_shared_latch;
  logic wr_five_latch;
  logic wr_first_dir;
  logic wr_shared_dir;
  logic wr_five_dir;

  always_comb begin
    wr_first_latch = 1'b0;
    wr_shared_latch = 1'b0;
    wr_five_latch = 1'b0;
    wr_first_dir = 1'b0;
    wr_shared_dir = 1'b0;
    wr_five_dir = 1'b0;
    if (req.wr) begin
      if (req.addr == `OFS_FIRST_LATCH) begin
        wr_first_latch = 1'b1;
      end else if (req.addr == `OFS_SHARED_LATCH) begin
        wr_shared_latch = 1'b1;
      end else if (req.addr == `OFS_FIVE_LATCH) begin
        wr_five_latch = 1'b1;
      end else if (req.addr == `OFS_FIRST_DIR) begin
        wr_first_dir = 1'b1;
      end else if (req.addr == `OFS_SHARED_DIR) begin
        wr_shared_dir = 1'b1;
      end else if (req.addr == `OFS_FIVE_DIR) begin
        wr_five_dir = 1'b1;
      end
    end
  end

  // Pin synchronisers ahead of the read path.
  pio_pin_sync #(
    .W (`DATA_W)
  ) u_first_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin_in   (first_port_in),
    .pin_sync (first_sync) // R17
  );

  pio_pin_sync #(
    .W (`DATA_W)
  ) u_shared_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin_in   (shared_port_in),
    .pin_sync (shared_sync) // R17
  );

  pio_pin_sync #(
    .W (`FIVE_W)
  ) u_five_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin_in   (five_port_in),
    .pin_sync (five_sync) // R17
  );

  // Latch next values; writes land whatever the direction bits hold, except five-bit pin 2 while clock output is enabled.
  always_comb begin
    first_port_latch_d = first_port_latch_q;
    analog_shared_port_latch_d = analog_shared_port_latch_q;
    five_bit_port_latch_d = five_bit_port_latch_q;
    if (wr_first_latch) begin
      first_port_latch_d = req.wdata; // R1 R6 R16
    end
    if (wr_shared_latch) begin
      analog_shared_port_latch_d = req.wdata; // R6 R11
    end
    if (wr_five_latch) begin
      five_bit_port_latch_d = req.wdata[`FIVE_W-1:0]; // R12
      // The clock pin keeps its latch while the clock is driven out.
      if (clock_output_enable_q) begin
        five_bit_port_latch_d[`CLK_OUT_PIN] =
          five_bit_port_latch_q[`CLK_OUT_PIN]; // R13
      end
    end
  end

  always_ff @(posedge clk) begin
    first_port_latch_q <= first_port_latch_d; // R1
    analog_shared_port_latch_q <= analog_shared_port_latch_d; // R11
    five_bit_port_latch_q <= five_bit_port_latch_d; // R12
  end

  // Direction next values.
  always_comb begin
    first_port_direction_d = first_port_direction_q;
    analog_shared_port_direction_d = analog_shared_port_direction_q;
    five_bit_port_direction_d = five_bit_port_direction_q;
    clock_output_enable_d = clock_output_enable_q;
    if (wr_first_dir) begin
      first_port_direction_d = req.wdata; // R2
    end
    if (wr_shared_dir) begin
      analog_shared_port_direction_d = req.wdata; // R2
    end
    if (wr_five_dir) begin
      five_bit_port_direction_d = req.wdata[`FIVE_W-1:0]; // R15
      clock_output_enable_d = req.wdata[`CLK_OUT_EN_BIT]; // R14
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_port_direction_q <= `DIR_RESET; // R3
      analog_shared_port_direction_q <= `DIR_RESET; // R11
      five_bit_port_direction_q <= `FIVE_DIR_RESET; // R15
      clock_output_enable_q <= `CLK_OUT_RESET; // R14
    end else begin
      first_port_direction_q <= first_port_direction_d;
      analog_shared_port_direction_q <= analog_shared_port_direction_d;
      five_bit_port_direction_q <= five_bit_port_direction_d;
      clock_output_enable_q <= clock_output_enable_d;
    end
  end

  // Pin ownership by the converter and by the clock output.
  always_comb begin
    analog_mask = chan_to_mask(converter_channel_select); // R8
    five_force = `ZERO_BYTE;
    five_force[`CLK_OUT_PIN] = clock_output_enable_q; // R13
  end

  pio_port_slice u_first_slice (
    .latch       (first_port_latch_q),
    .dir         (first_port_direction_q),
    .analog      (`ZERO_BYTE),
    .force_drive (`ZERO_BYTE),
    .pin_sync    (first_sync),
    .view        (first_view)
  );

  pio_port_slice u_shared_slice (
    .latch       (analog_shared_port_latch_q),
    .dir         (analog_shared_port_direction_q),
    .analog      (analog_mask),
    .force_drive (`ZERO_BYTE),
    .pin_sync    (shared_sync),
    .view        (shared_view)
  );

  pio_port_slice u_five_slice (
    .latch       (widen(five_bit_port_latch_q)),
    .dir         (widen(five_bit_port_direction_q)),
    .analog      (`ZERO_BYTE),
    .force_drive (five_force),
    .pin_sync    (widen(five_sync)),
    .view        (five_view)
  );

  // Read data stand only in the cycle after the read strobe.
  always_comb begin
    rd_data_d = `READ_IDLE;
    if (req.rd) begin
      if (req.addr == `OFS_FIRST_LATCH) begin
        rd_data_d = first_view.rd_val; // R4 R5
      end else if (req.addr == `OFS_SHARED_LATCH) begin
        rd_data_d = shared_view.rd_val; // R9
      end else if (req.addr == `OFS_FIVE_LATCH) begin
        rd_data_d = five_view.rd_val;
      end else if (req.addr == `OFS_FIRST_DIR) begin
        rd_data_d = first_port_direction_q;
      end else if (req.addr == `OFS_SHARED_DIR) begin
        rd_data_d = analog_shared_port_direction_q;
      end else if (req.addr == `OFS_FIVE_DIR) begin
        rd_data_d = widen(five_bit_port_direction_q); // R15
        rd_data_d[`CLK_OUT_EN_BIT] = clock_output_enable_q; // R14
      end
    end
  end

  // Registered pin drives.
  logic [`DATA_W-1:0] first_out_q;
  logic [`DATA_W-1:0] first_oe_n_q;
  logic [`DATA_W-1:0] shared_out_q;
  logic [`DATA_W-1:0] shared_oe_n_q;
  logic [`FIVE_W-1:0] five_out_q;
  logic [`FIVE_W-1:0] five_oe_n_q;
  logic [`DATA_W-1:0] first_out_d;
  logic [`DATA_W-1:0] first_oe_n_d;
  logic [`DATA_W-1:0] shared_out_d;
  logic [`DATA_W-1:0] shared_oe_n_d;
  logic [`FIVE_W-1:0] five_out_d;
  logic [`FIVE_W-1:0] five_oe_n_d;

  always_comb begin
    first_out_d = first_view.out;
    first_oe_n_d = first_view.oe_n; // R2
    shared_out_d = shared_view.out;
    shared_oe_n_d = shared_view.oe_n; // R8
    five_out_d = five_view.out[`FIVE_W-1:0];
    five_oe_n_d = five_view.oe_n[`FIVE_W-1:0]; // R2
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_q <= `READ_IDLE;
      first_out_q <= `ZERO_BYTE;
      first_oe_n_q <= ~`DIR_RESET;
      shared_out_q <= `ZERO_BYTE;
      shared_oe_n_q <= ~`DIR_RESET;
      five_out_q <= `FIVE_DIR_RESET;
      five_oe_n_q <= ~`FIVE_DIR_RESET;
    end else begin
      rd_data_q <= rd_data_d;
      first_out_q <= first_out_d;
      first_oe_n_q <= first_oe_n_d;
      shared_out_q <= shared_out_d;
      shared_oe_n_q <= shared_oe_n_d;
      five_out_q <= five_out_d;
      five_oe_n_q <= five_oe_n_d;
    end
  end

  // The clock pin carries the bus clock itself, which no flop can
  // reproduce; its enable is clock_output_enable_q registered once more in clk_out_on_q.
  logic clk_out_on_q;
  logic clk_out_on_d;

  always_comb begin
    clk_out_on_d = clock_output_enable_q;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_out_on_q <= `CLK_OUT_RESET;
    end else begin
      clk_out_on_q <= clk_out_on_d;
    end
  end

  always_comb begin
    five_port_out = five_out_q;
    if (clk_out_on_q) begin
      five_port_out[`CLK_OUT_PIN] = clk; // R13
    end
  end

  assign rd_data = rd_data_q;
  assign first_port_out = first_out_q;
  assign first_port_oe_n = first_oe_n_q;
  assign shared_port_out = shared_out_q;
  assign shared_port_oe_n = shared_oe_n_q;
  assign five_port_oe_n = five_oe_n_q;

endmodule : pio_ports_abc

// [pio_board.sv]
// Board circuitry facing the three parallel ports as one 21-pin bundle.
// Assumes active-low enables: a low enable means the block drives.
`timescale 1ns/1ns

module pio_board #(
  parameter int W = 21
) (
  input  wire logic [W-1:0] drv,
  input  wire logic [W-1:0] oe_n,
  input  wire logic [W-1:0] ext,
  output logic      [W-1:0] pin
);
  // The board only wins on pins that the block has released.
  assign pin = (drv & ~oe_n) | (ext & oe_n);
endmodule : pio_board

// [pio_ports_abc_properties.sv]
// Port-level assertions for the three-port parallel I/O block.
// Assumes one clock domain and registered pin outputs.
`timescale 1ns/1ns
`include "pio_ports_map.svh"

module pio_ports_abc_properties (
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire logic [`ADDR_W-1:0]     addr,
  input wire logic [`DATA_W-1:0]     wdata,
  input wire logic                   wr_stb,
  input wire logic                   rd_stb,
  input wire logic [`DATA_W-1:0]     rd_data,
  input wire logic [`CHAN_SEL_W-1:0] converter_channel_select,
  input wire logic [`DATA_W-1:0]     first_port_out,
  input wire logic [`DATA_W-1:0]     first_port_oe_n,
  input wire logic [`DATA_W-1:0]     shared_port_out,
  input wire logic [`DATA_W-1:0]     shared_port_oe_n,
  input wire logic [`FIVE_W-1:0]     five_port_out,
  input wire logic [`FIVE_W-1:0]     five_port_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_rst_release;
    $fell(sys_rst) |-> first_port_oe_n == 8'hff && shared_port_oe_n == 8'hff
      && five_port_oe_n == 5'h1f && rd_data == 8'h00;
  endproperty
  a_rst_release: assert property (p_rst_release)
    else $error("pins not released after reset");

  property p_rd_idle;
    !$past(rd_stb) |-> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its cycle");

  property p_rd_unmapped;
    rd_stb && addr inside {8'h03, [8'h07:8'hff]} |=> rd_data == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");

  property p_no_drive_released;
    (first_port_out & first_port_oe_n) == 8'h00
      && (shared_port_out & shared_port_oe_n) == 8'h00
      && (five_port_out & five_port_oe_n & 5'h1b) == 5'h00;
  endproperty
  a_no_drive_released: assert property (p_no_drive_released)
    else $error("released pin carries data");

  property p_dir_to_drive;
    wr_stb && addr == 8'h04 |-> ##2 first_port_oe_n == ~$past(wdata, 2);
  endproperty
  a_dir_to_drive: assert property (p_dir_to_drive)
    else $error("direction write not seen on enables");

  property p_owned_float;
    $past(converter_channel_select) < 5'h08
      |-> shared_port_oe_n[$past(converter_channel_select[2:0])];
  endproperty
  a_owned_float: assert property (p_owned_float)
    else $error("converter pin driven");

  property p_read_latch;
    rd_stb && addr == 8'h00 && first_port_oe_n == 8'h00 && !$past(wr_stb)
      |=> rd_data == first_port_out;
  endproperty
  a_read_latch: assert property (p_read_latch)
    else $error("output pin read not latch");

  property p_clk_out_on;
    wr_stb && addr == 8'h06 && wdata[7] |-> ##2 !five_port_oe_n[2];
  endproperty
  a_clk_out_on: assert property (p_clk_out_on)
    else $error("clock output pin not driving");

  c_dir_write: cover property (wr_stb && addr == 8'h04);
  c_read_latch: cover property (rd_stb && addr == 8'h00
    && first_port_oe_n == 8'h00);
  c_clk_out: cover property (wr_stb && addr == 8'h06 && wdata[7]);
endmodule : pio_ports_abc_properties

bind pio_ports_abc pio_ports_abc_properties i_pio_ports_abc_properties (
  .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
  .converter_channel_select(converter_channel_select),
  .first_port_out(first_port_out), .first_port_oe_n(first_port_oe_n),
  .shared_port_out(shared_port_out), .shared_port_oe_n(shared_port_oe_n),
  .five_port_out(five_port_out), .five_port_oe_n(five_port_oe_n)
);

// [pio_ports_abc_tb.sv]
// Self-checking bench for the three-port parallel I/O block.
// Assumes the board model and the bound checker are compiled first.
`timescale 1ns/1ns
`include "pio_ports_map.svh"

module pio_ports_abc_tb;
  logic        clk, sys_rst, wr_stb, rd_stb;
  logic [7:0]  addr, wdata, rd_data, first_port_out, first_port_oe_n;
  logic [7:0]  shared_port_out, shared_port_oe_n;
  logic [4:0]  five_port_out, five_port_oe_n, ch, ch_r;
  logic [7:0]  ext [3];
  logic [7:0]  lat, dir, pin, own, msk, d, oe_got, out_got;
  wire  [20:0] pins;
  int          n_errors, cmp_count, seed, i, p;

  pio_ports_abc i_pio_ports_abc (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .converter_channel_select(ch),
    .first_port_in(pins[20:13]), .first_port_out(first_port_out),
    .first_port_oe_n(first_port_oe_n),
    .shared_port_in(pins[12:5]), .shared_port_out(shared_port_out),
    .shared_port_oe_n(shared_port_oe_n),
    .five_port_in(pins[4:0]), .five_port_out(five_port_out),
    .five_port_oe_n(five_port_oe_n));

  pio_board #(.W(21)) i_pio_board (
    .drv({first_port_out, shared_port_out, five_port_out}),
    .oe_n({first_port_oe_n, shared_port_oe_n, five_port_oe_n}),
    .ext({ext[0], ext[1], ext[2][4:0]}), .pin(pins));

  always #25 clk = ~clk;

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rd_data;
  endtask : bus_rd

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] rd_exp(input logic [7:0] l, dr, pn, ow);
    return (dr & l) | (~dr & ~ow & pn);
  endfunction : rd_exp

  task automatic check_reset;
    for (int a = 4; a < 7; a++) begin
      bus_rd(a[7:0], d);
      chk(d, 8'h00);
    end
    chk(first_port_oe_n & shared_port_oe_n, 8'hff);
    chk({3'h0, five_port_oe_n}, 8'h1f);
  endtask : check_reset

  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  initial begin
    #(20000 * 50);
    n_errors++;
    end_of_test;
  end

  initial begin
    seed = 32'hd7f5;
    n_errors = 0;
    cmp_count = 0;
    clk = 1'b0;
    sys_rst = 1'b1;
    {addr, wdata, wr_stb, rd_stb} = 18'h0;
    ch = 5'h1f;
    ext = '{8'h00, 8'h00, 8'h00};
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    check_reset;
    $display("test reset done");
    // Random latch, direction, pin and channel mixes on every port.
    for (i = 0; i < 30; i++) begin
      for (p = 0; p < 3; p++) begin
        lat  = 8'($random(seed));
        pin  = 8'($random(seed));
        ch_r = 5'($random(seed));
        msk  = (p == 2) ? 8'h1f : 8'hff;
        dir  = 8'($random(seed)) & msk;
        own  = (p == 1 && ch_r < 5'h08) ? (8'h01 << ch_r[2:0]) : 8'h00;
        @(posedge clk);
        ext[p] <= pin;
        ch <= ch_r;
        bus_wr(p[7:0], lat);
        bus_wr(p[7:0] + 8'h04, dir);
        repeat (3) @(posedge clk);
        bus_rd(p[7:0], d);
        chk(d, rd_exp(lat, dir, pin, own) & msk);
        case (p)
          0: begin oe_got = first_port_oe_n; out_got = first_port_out; end
          1: begin oe_got = shared_port_oe_n; out_got = shared_port_out; end
          default: begin
            oe_got = {3'h0, five_port_oe_n};
            out_got = {3'h0, five_port_out};
          end
        endcase
        chk(oe_got, (~dir | own) & msk);
        chk(out_got, lat & dir & ~own & msk);
      end
    end
    $display("test random done");
    bus_wr(8'h00, 8'ha5);
    bus_wr(8'h01, 8'h3c);
    bus_wr(8'h02, 8'h16);
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    check_reset;
    @(posedge clk);
    ch <= 5'h1f;
    bus_wr(8'h04, 8'hff);
    bus_wr(8'h05, 8'hff);
    bus_wr(8'h06, 8'h1f);
    bus_rd(8'h00, d);
    chk(d, 8'ha5);
    bus_rd(8'h01, d);
    chk(d, 8'h3c);
    bus_rd(8'h02, d);
    chk(d, 8'h16);
    $display("test latch hold done");
    bus_wr(8'h06, 8'h9f);
    repeat (2) @(posedge clk);
    bus_rd(8'h06, d);
    chk(d, 8'h9f);
    bus_rd(8'h02, d);
    chk(d, 8'h16);
    bus_wr(8'h02, 8'h0b);
    bus_rd(8'h02, d);
    chk(d, 8'h0f);
    @(posedge clk);
    #10 chk({7'h0, five_port_out[2]}, 8'h01);
    @(negedge clk);
    #10 chk({7'h0, five_port_out[2]}, 8'h00);
    bus_wr(8'h06, 8'h00);
    bus_rd(8'h06, d);
    chk(d, 8'h00);
    $display("test clock output done");
    foreach (ext[k]) begin
      bus_wr(8'h03 + 8'h04 * k[7:0], 8'h00);
      bus_rd(8'h03 + 8'h04 * k[7:0], d);
      chk(d, 8'h00);
    end
    bus_rd(8'h04, d);
    chk(d, 8'hff);
    bus_rd(8'hff, d);
    chk(d, 8'h00);
    $display("test unmapped done");
    end_of_test;
  end
endmodule : pio_ports_abc_tb
